// [hdl/event_irq_regs.svh]
// Purpose: Register offsets, field positions and reset values of the host event block
// Assumes: Byte addresses on an AXI4-Lite bus with 32-bit data
// Notes:   Printed offsets are not all multiples of four, so each is an index
`ifndef EVENT_IRQ_REGS_SVH
`define EVENT_IRQ_REGS_SVH

`define IDX_RAW_STATUS_LOW      8'hF0
`define IDX_RAW_STATUS_HIGH     8'hF1
`define IDX_MASKED_STATUS_LOW   8'hF2
`define IDX_MASKED_STATUS_HIGH  8'hF3
`define IDX_ENABLE_LOW          8'hF4
`define IDX_ENABLE_HIGH         8'hF5
`define IDX_CLEAR_LOW           8'hF6
`define IDX_CLEAR_HIGH          8'hF7
`define IDX_ACCESS_STATUS       8'hF8
`define IDX_ACCESS_ENABLE       8'hF9

`define ENABLE_LOW_RESET        8'h00
`define ENABLE_HIGH_RESET       3'h0
`define HIGH_FIELD_MSB          2

`define BIT_FIFO_FULL           0
`define BIT_STANDARD_CHANGED    1
`define BIT_COPY_PROT_CHANGED   2

`define BIT_ACC_UNMAPPED_WRITE  0
`define BIT_ACC_UNMAPPED_READ   1

`define AXI_RESP_OKAY           2'h0
`define AXI_RESP_SLVERR         2'h2

`endif

// [hdl/event_irq_pkg.sv]
// Purpose: Types shared by the host event block and its bench
// Assumes: Constants live in event_irq_regs.svh
// Notes:   Low group is eight sources, six of them data-available; high group is FIFO full and two changes
package event_irq_pkg;

    typedef struct packed {
        logic fifo_threshold_passed;
        logic teletext_available;
        logic wide_screen_available;
        logic program_delivery_available;
        logic timecode_available;
        logic caption_field2_available;
        logic caption_field1_available;
        logic line_number_hit;
    } low_events_t;

    typedef struct packed {
        logic copy_protect_changed;
        logic standard_changed;
        logic fifo_full;
    } high_events_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic       awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic       wvalid;
        logic       bready;
        logic [7:0] araddr;
        logic       arvalid;
        logic       rready;
    } axil_req_t;

    typedef struct packed {
        logic       awready;
        logic       wready;
        logic [1:0] bresp;
        logic       bvalid;
        logic       arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic       rvalid;
    } axil_rsp_t;

endpackage

// [hdl/vbi_host_interrupt_ctrl.sv]
// Purpose: Host event flags, enables, clears and the interrupt pin of the video decoder
// Assumes: Event pulses come from logic on aclk; FIFO full pulse marks a refused write
// Notes:   Registers are word-wide, data in bits 7:0, byte address = index * 4
// Functional notes
// - Pin active when any enabled flag set
// - Pin inactive once no enabled flag remains
// - Low enable register, eight sources, reset disabled
// - High enable register, three sources, reset disabled
// - High masked status register is read-only
// - FIFO full flag marks a refused write
// - Writing one clears flag, zero does nothing
// - Low clear bit n clears low flag n
// - High clear bits clear raw and masked
// - Masked bit is raw AND enable
// - Reading event status leaves flags unchanged
`timescale 1ns/1ps
`include "event_irq_regs.svh"

module vbi_host_interrupt_ctrl (
    // Clock and reset
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    // Register bus
    input  wire event_irq_pkg::axil_req_t    axil_req,
    output event_irq_pkg::axil_rsp_t         axil_rsp,
    // Event pulses from the decoder, one cycle each
    input  wire event_irq_pkg::low_events_t  low_event_set,
    input  wire event_irq_pkg::high_events_t high_event_set,
    // Interrupt pin, active high
    output logic                             host_irq
);
    import event_irq_pkg::*;

    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_HAVE = 3'b010,
        WR_RESP = 3'b100
    } wr_state_t;

    low_events_t  raw_low_ff;
    high_events_t raw_high_ff;
    logic [7:0]   enable_low_ff;
    logic [2:0]   enable_high_ff;
    logic [7:0]   masked_low;
    logic [2:0]   masked_high;
    logic [1:0]   acc_status_ff;
    logic [1:0]   acc_enable_ff;
    logic         acc_irq;

    wr_state_t    wr_state_ff;
    logic         aw_held_ff;
    logic         w_held_ff;
    logic [7:0]   awaddr_ff;
    logic [31:0]  wdata_ff;
    logic [3:0]   wstrb_ff;
    logic [1:0]   bresp_ff;
    logic         bvalid_ff;
    logic         rvalid_ff;
    logic [31:0]  rdata_ff;
    logic [1:0]   rresp_ff;

    logic         wr_fire;
    logic [7:0]   wr_index;
    logic [7:0]   rd_index;
    logic         lane0;
    logic         wr_mapped;
    logic [7:0]   clear_low;
    logic [2:0]   clear_high;
    logic         rd_fire;
    logic [31:0]  nxt_rdata;
    logic         nxt_rd_mapped;

    // Word index: the low byte of every index sits at byte address index*4.
    // An 8-bit bus reaches only indices C0..FF, so the top two index bits are implied
    assign wr_index = {2'b11, awaddr_ff[7:2]};
    assign rd_index = {2'b11, axil_req.araddr[7:2]};
    assign lane0    = wstrb_ff[0];

    assign masked_low  = raw_low_ff & enable_low_ff;
    assign masked_high = raw_high_ff & enable_high_ff;

    // Pin follows the registered enabled flags combinationally, so it drops the cycle after the clear strobe
    assign acc_irq  = |(acc_status_ff & acc_enable_ff);
    assign host_irq = (|masked_low) | (|masked_high) | acc_irq;

    // Write channel: address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            awaddr_ff  <= 8'h00;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end else if (axil_req.awvalid && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            awaddr_ff  <= axil_req.awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wstrb_ff  <= 4'h0;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end else if (axil_req.wvalid && !w_held_ff) begin
            w_held_ff <= 1'b1;
            wdata_ff  <= axil_req.wdata;
            wstrb_ff  <= axil_req.wstrb;
        end
    end

    assign wr_fire = (wr_state_ff == WR_HAVE);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= WR_IDLE;
        end else begin
            case (wr_state_ff)
                WR_IDLE: begin
                    if (aw_held_ff && w_held_ff) begin
                        wr_state_ff <= WR_HAVE;
                    end
                end
                WR_HAVE: begin
                    wr_state_ff <= WR_RESP;
                end
                WR_RESP: begin
                    if (axil_req.bready) begin
                        wr_state_ff <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_ff <= WR_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        case (wr_index)
            `IDX_ENABLE_LOW, `IDX_ENABLE_HIGH, `IDX_CLEAR_LOW, `IDX_CLEAR_HIGH,
            `IDX_ACCESS_STATUS, `IDX_ACCESS_ENABLE: wr_mapped = 1'b1;
            default:                                wr_mapped = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= `AXI_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (bvalid_ff && axil_req.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_low_ff  <= `ENABLE_LOW_RESET;
            enable_high_ff <= `ENABLE_HIGH_RESET;
            acc_enable_ff  <= 2'h0;
        end else if (wr_fire && lane0) begin
            if (wr_index == `IDX_ENABLE_LOW) begin
                enable_low_ff <= wdata_ff[7:0];
            end
            if (wr_index == `IDX_ENABLE_HIGH) begin
                enable_high_ff <= wdata_ff[`HIGH_FIELD_MSB:0];
            end
            if (wr_index == `IDX_ACCESS_ENABLE) begin
                acc_enable_ff <= wdata_ff[1:0];
            end
        end
    end

    // Clear strobes last the single write cycle; zeros leave flags alone
    assign clear_low  = (wr_fire && lane0 && wr_index == `IDX_CLEAR_LOW)
                        ? wdata_ff[7:0] : 8'h00;
    assign clear_high = (wr_fire && lane0 && wr_index == `IDX_CLEAR_HIGH)
                        ? wdata_ff[`HIGH_FIELD_MSB:0] : 3'h0;

    // One raw flag set lives per source; the masked view is derived, so clearing
    // the raw flag clears both views together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_low_ff <= '0;
        end else begin
            raw_low_ff <= (raw_low_ff & ~clear_low) | low_event_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_high_ff <= '0;
        end else begin
            // FIFO full pulse is driven only by a write the FIFO refused
            raw_high_ff <= (raw_high_ff & ~clear_high) | high_event_set;
        end
    end

    // Bus access errors: sticky, cleared by reading their own status register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc_status_ff <= 2'h0;
        end else begin
            acc_status_ff <= (acc_status_ff &
                              ~{2{rd_fire && rd_index == `IDX_ACCESS_STATUS}})
                             | {rd_fire && !nxt_rd_mapped, wr_fire && !wr_mapped};
        end
    end

    // Read channel, one read outstanding
    assign rd_fire = axil_req.arvalid && !rvalid_ff;

    always_comb begin
        nxt_rdata     = 32'h0000_0000;
        nxt_rd_mapped = 1'b1;
        case (rd_index)
            `IDX_RAW_STATUS_LOW:     nxt_rdata[7:0] = raw_low_ff;
            `IDX_RAW_STATUS_HIGH:    nxt_rdata[2:0] = raw_high_ff;
            `IDX_MASKED_STATUS_LOW:  nxt_rdata[7:0] = masked_low;
            `IDX_MASKED_STATUS_HIGH: nxt_rdata[2:0] = masked_high;
            `IDX_ENABLE_LOW:         nxt_rdata[7:0] = enable_low_ff;
            `IDX_ENABLE_HIGH:        nxt_rdata[2:0] = enable_high_ff;
            `IDX_CLEAR_LOW:          nxt_rdata[7:0] = 8'h00;
            `IDX_CLEAR_HIGH:         nxt_rdata[2:0] = 3'h0;
            `IDX_ACCESS_STATUS:      nxt_rdata[1:0] = acc_status_ff;
            `IDX_ACCESS_ENABLE:      nxt_rdata[1:0] = acc_enable_ff;
            default:                 nxt_rd_mapped  = 1'b0;
        endcase
    end

    // Reading event status has no side effect on the flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= `AXI_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rd_mapped ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
        end else if (rvalid_ff && axil_req.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    always_comb begin
        axil_rsp.awready = !aw_held_ff;
        axil_rsp.wready  = !w_held_ff;
        axil_rsp.bresp   = bresp_ff;
        axil_rsp.bvalid  = bvalid_ff;
        axil_rsp.arready = !rvalid_ff;
        axil_rsp.rdata   = rdata_ff;
        axil_rsp.rresp   = rresp_ff;
        axil_rsp.rvalid  = rvalid_ff;
    end

endmodule

// [tb/vbi_host_interrupt_ctrl_properties.sv]
// Purpose: Port-level checks of the host event block
// Assumes: Address and data taken at one edge by the bench host
// Notes:   Pin moves only on events, writes or reads
`timescale 1ns/1ps
module vbi_host_interrupt_ctrl_properties (
    // Clock and reset
    input wire logic                        aclk,
    input wire logic                        aresetn,
    // Ports watched
    input wire event_irq_pkg::axil_req_t    axil_req,
    input wire event_irq_pkg::axil_rsp_t    axil_rsp,
    input wire event_irq_pkg::low_events_t  low_event_set,
    input wire event_irq_pkg::high_events_t high_event_set,
    input wire logic                        host_irq
);
    import event_irq_pkg::*;
    logic wtake;
    logic rtake;
    assign wtake = axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready;
    assign rtake = axil_req.arvalid && axil_rsp.arready;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_b_after_w;
        wtake |=> !axil_rsp.bvalid ##1 !axil_rsp.bvalid ##1 axil_rsp.bvalid;
    endproperty
    a_b_after_w: assert property (p_b_after_w) else $error("write answer late or early");
    property p_r_after_ar;
        rtake |=> axil_rsp.rvalid;
    endproperty
    a_r_after_ar: assert property (p_r_after_ar) else $error("read answer late");
    property p_rdata_upper;
        axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 24'h000000;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits not zero");
    property p_b_hold;
        axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_irq_reset;
        disable iff (1'b0) !aresetn |=> !host_irq;
    endproperty
    a_irq_reset: assert property (p_irq_reset) else $error("pin active after reset");
    property p_irq_fall;
        $fell(host_irq) |-> $past(wtake, 3) || $past(rtake) || $past(rtake, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("pin fell without host access");
    property p_irq_rise;
        $rose(host_irq) |-> $past(|{low_event_set, high_event_set}) || $past(wtake, 3);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("pin rose without cause");
endmodule

bind vbi_host_interrupt_ctrl vbi_host_interrupt_ctrl_properties
    vbi_host_interrupt_ctrl_properties_inst (.aclk(aclk), .aresetn(aresetn),
    .axil_req(axil_req), .axil_rsp(axil_rsp), .low_event_set(low_event_set),
    .high_event_set(high_event_set), .host_irq(host_irq));

// [tb/host_model.sv]
// Purpose: Host processor issuing AXI4-Lite register accesses
// Assumes: One access at a time; byte address is index times four
// Notes:   Waits without limit, the bench watchdog ends a hang
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic                     aclk,
    // Register bus
    output event_irq_pkg::axil_req_t      req,
    input  wire event_irq_pkg::axil_rsp_t rsp
);
    import event_irq_pkg::*;
    initial req = '0;
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, output logic [1:0] r);
        logic aw_pend;
        logic w_pend;
        logic aw_take;
        logic w_take;
        @(posedge aclk);
        req.awaddr  <= {idx[5:0], 2'h0};
        req.wdata   <= {24'h000000, d};
        req.wstrb   <= 4'h1;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        aw_pend = 1'b1;
        w_pend  = 1'b1;
        // Readies settle mid-cycle and hold to the next rising edge
        while (aw_pend || w_pend) begin
            @(negedge aclk);
            aw_take = aw_pend && rsp.awready;
            w_take  = w_pend && rsp.wready;
            @(posedge aclk);
            if (aw_take) req.awvalid <= 1'b0;
            if (w_take) req.wvalid <= 1'b0;
            if (aw_take) aw_pend = 1'b0;
            if (w_take) w_pend = 1'b0;
        end
        do @(negedge aclk); while (!rsp.bvalid);
        r = rsp.bresp;
        @(posedge aclk);
        req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        req.araddr  <= {idx[5:0], 2'h0};
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        do @(negedge aclk); while (!rsp.arready);
        @(posedge aclk);
        req.arvalid <= 1'b0;
        do @(negedge aclk); while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
        @(posedge aclk);
        req.rready <= 1'b0;
    endtask
endmodule

// [tb/vbi_host_interrupt_ctrl_bench.sv]
// Purpose: Self-checking bench of the host event block
// Assumes: Registers carry data in bits 7:0
// Notes:   Every event source walks set, enable, clear and pin release
`timescale 1ns/1ps
`include "event_irq_regs.svh"
module vbi_host_interrupt_ctrl_bench;
    import event_irq_pkg::*;
    logic         aclk;
    logic         aresetn;
    logic         host_irq;
    axil_req_t    req;
    axil_rsp_t    rsp;
    low_events_t  lo_ev;
    high_events_t hi_ev;
    logic [31:0]  rd_d;
    logic [1:0]   resp;
    int           mismatches;
    int           n_tests;
    vbi_host_interrupt_ctrl vbi_host_interrupt_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
        .axil_req(req), .axil_rsp(rsp), .low_event_set(lo_ev), .high_event_set(hi_ev),
        .host_irq(host_irq));
    host_model host_model_inst (.aclk(aclk), .req(req), .rsp(rsp));
    task automatic tally_and_finish;
        if (mismatches == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
        host_model_inst.rd(idx, rd_d, resp);
        chk($sformatf("reg %h", idx), {24'h000000, e}, rd_d);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host_model_inst.wr(idx, d, resp);
    endtask
    task automatic irq(input logic e);
        chk("host_irq", {31'h0, e}, {31'h0, host_irq});
    endtask
    task automatic flag_case(input int b);
        logic [7:0] m;
        logic [7:0] g;
        g = (b > 7) ? 8'h01 : 8'h00;
        m = 8'h01 << ((b > 7) ? b - 8 : b);
        @(posedge aclk);
        if (b > 7) hi_ev <= high_events_t'(m[2:0]);
        else lo_ev <= low_events_t'(m);
        @(posedge aclk);
        lo_ev <= '0;
        hi_ev <= '0;
        rdchk(`IDX_RAW_STATUS_LOW + g, m);
        rdchk(`IDX_MASKED_STATUS_LOW + g, 8'h00);
        irq(1'b0);
        wr(`IDX_ENABLE_LOW + g, m);
        irq(1'b1);
        rdchk(`IDX_ENABLE_LOW + g, m);
        wr(`IDX_MASKED_STATUS_LOW + g, 8'h00);
        rdchk(`IDX_MASKED_STATUS_LOW + g, m);
        wr(`IDX_CLEAR_LOW + g, ~m);
        rdchk(`IDX_RAW_STATUS_LOW + g, m);
        wr(`IDX_CLEAR_LOW + g, m);
        irq(1'b0);
        rdchk(`IDX_RAW_STATUS_LOW + g, 8'h00);
        wr(`IDX_ENABLE_LOW + g, 8'h00);
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        repeat (5000) @(posedge aclk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        aresetn    = 1'b0;
        lo_ev      = '0;
        hi_ev      = '0;
        mismatches = 0;
        n_tests    = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rdchk(`IDX_ENABLE_LOW, `ENABLE_LOW_RESET);
        rdchk(`IDX_ENABLE_HIGH, 8'h00);
        for (int b = 0; b < 11; b++) begin
            flag_case(b);
        end
        // Set held across the whole clear write
        wr(`IDX_ENABLE_HIGH, 8'h01);
        hi_ev <= 3'h1;
        wr(`IDX_CLEAR_HIGH, 8'h01);
        hi_ev <= '0;
        irq(1'b1);
        wr(`IDX_CLEAR_HIGH, 8'h01);
        irq(1'b0);
        host_model_inst.wr(8'hFB, 8'h00, resp);
        chk("bresp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, resp});
        host_model_inst.rd(8'hFA, rd_d, resp);
        chk("rresp", {30'h0, `AXI_RESP_SLVERR}, {30'h0, resp});
        rdchk(`IDX_ACCESS_STATUS, 8'h03);
        rdchk(`IDX_ACCESS_STATUS, 8'h00);
        tally_and_finish;
    end
endmodule
